//--- rtl/lcfs_cfg.svh
/*
 * timing constants for the led channel fault supervisor.
 * assumes a 50 mhz core clock; included by bare name.
 */
`ifndef LCFS_CFG_SVH
`define LCFS_CFG_SVH

`define LCFS_CLK_MHZ 50
`define LCFS_PWM_RISE_US 17
`define LCFS_PWM_FALL_US 21
`define LCFS_STARTUP_US 100
`define LCFS_OVERTEMP_US 60
`define LCFS_OPEN_US 125
`define LCFS_GSHORT_US 125
`define LCFS_LSHORT_US 125
`define LCFS_RECOVER_US 16
`define LCFS_PWM_RISE_CYC (`LCFS_PWM_RISE_US * `LCFS_CLK_MHZ)
`define LCFS_PWM_FALL_CYC (`LCFS_PWM_FALL_US * `LCFS_CLK_MHZ)
`define LCFS_STARTUP_CYC (`LCFS_STARTUP_US * `LCFS_CLK_MHZ)
`define LCFS_OVERTEMP_CYC (`LCFS_OVERTEMP_US * `LCFS_CLK_MHZ)
`define LCFS_OPEN_CYC (`LCFS_OPEN_US * `LCFS_CLK_MHZ)
`define LCFS_GSHORT_CYC (`LCFS_GSHORT_US * `LCFS_CLK_MHZ)
`define LCFS_LSHORT_CYC (`LCFS_LSHORT_US * `LCFS_CLK_MHZ)
`define LCFS_RECOVER_CYC (`LCFS_RECOVER_US * `LCFS_CLK_MHZ)
`define LCFS_CNT_W 16

`endif

//--- rtl/lcfs_pkg.sv
/*
 * types shared by the supervisor and its deglitch filter.
 * assumes lcfs_cfg.svh for widths.
 */
`include "lcfs_cfg.svh"
package lcfs_pkg;
	typedef logic [`LCFS_CNT_W-1:0] lcfs_cnt_t;

	typedef enum logic [1:0] {
		LCFS_SLEEP = 2'b00,
		LCFS_START = 2'b01,
		LCFS_RUN = 2'b10
	} lcfs_mode_e;

	// raw comparator levels from the analog front end
	typedef struct packed {
		logic open_assert_level;
		logic open_release_level;
		logic ground_short_assert_level;
		logic ground_short_release_level;
		logic string_short;
		logic overtemp;
	} lcfs_sense_s;

	// confirmed fault flags
	typedef struct packed {
		logic open;
		logic gshort;
		logic lshort;
		logic overtemp;
	} lcfs_fault_s;

	// drive commands to the analog output stage
	typedef struct packed {
		logic main_on;
		logic retry_on;
	} lcfs_drive_s;
endpackage

//--- rtl/lcfs_deglitch.sv
/*
 * one deglitch filter: a fault flag that sets after the set condition
 * holds for set_count cycles and clears after the clear condition holds
 * for clr_count cycles. assumes synchronous level inputs.
 */
`timescale 1ns/1ps
module lcfs_deglitch
	import lcfs_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control
	input wire logic arm,
	input wire logic set_cond,
	input wire logic restart,
	input wire logic clr_cond,
	input wire lcfs_cnt_t set_count,
	input wire lcfs_cnt_t clr_count,
	// result
	output logic flag
);
	lcfs_cnt_t cnt;
	lcfs_cnt_t next_cnt;
	logic next_flag;

	// count toward set while clear, toward clear while set
	always_comb begin
		next_cnt = cnt;
		next_flag = flag;
		if (!flag) begin
			if (!arm || restart || !set_cond) begin
				next_cnt = '0;
			end else if (cnt + 16'h0001 >= set_count) begin
				next_cnt = '0;
				next_flag = 1'b1;
			end else begin
				next_cnt = cnt + 16'h0001;
			end
		end else begin
			if (!clr_cond) begin
				next_cnt = '0;
			end else if (cnt + 16'h0001 >= clr_count) begin
				next_cnt = '0;
				next_flag = 1'b0;
			end else begin
				next_cnt = cnt + 16'h0001;
			end
		end
	end

	// register state
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= '0;
			flag <= 1'b0;
		end else begin
			cnt <= next_cnt;
			flag <= next_flag;
		end
	end
endmodule

//--- rtl/lcfs_supervisor.sv
/*
 * digital supervisor of a single-channel linear led driver: enable and
 * pwm gating, start-up timing, fault deglitching, retry and fault bus.
 * assumes all inputs synchronous to core_clk, and sys_rst driven by the
 * supply power-on-reset comparator.
 */
// How it works
// RL1: current starts 17 us after pwm rises, stops 21 us after it falls.
// RL2: overtemperature must hold 60 us before it is acted upon.
// RL3: output current starts 100 us after enable rises.
// RL4: open circuit must hold 125 us before it becomes a fault.
// RL5: ground short must hold 125 us before it becomes a fault.
// RL6: single led short must hold 125 us before it becomes a fault.
// RL7: a fault clears only after its removal holds 16 us.
// RL8: all logic stays reset while the supply reset is high.
// RL9: bus pulled low by others turns output off, minimal current mode.
// RL10: an internal fault sinks the shared fault bus low.
// RL11: enable low means sleep, output off, timers idle; the pwm delay counter still runs in sleep.
// RL12: pwm gates output current and suspends diagnostics while low.
// RL13: diag gate input enables open and single led short checks.
// RL14: short to battery reports through the open circuit path.
// RL15: headroom low for open interval with pwm on sets open fault.
// RL16: headroom above release level restarts the open timer.
// RL17: open retry keeps output on with pwm, retry current without.
// RL18: open recovery returns to normal and releases the fault bus.
// RL19: output low for ground short interval sets fault, sinks bus.
// RL20: output above release level resets the ground short timer.
// RL21: ground short keeps main off, retry current on, ignores pwm.
// RL22: output above release level clears ground short fault.
// RL23: bus low shuts every driver off unless pulled up externally.
// RL24: single led short turns output off and retries with small current.
// RL25: overtemperature keeps output off and bus low until it cools.
// RL26: comparators are synchronous levels, intervals counted in cycles.
`timescale 1ns/1ps
module lcfs_supervisor
	import lcfs_pkg::*;
#(
	parameter lcfs_cnt_t PWM_RISE_CYC = lcfs_cnt_t'(`LCFS_PWM_RISE_CYC),
	parameter lcfs_cnt_t PWM_FALL_CYC = lcfs_cnt_t'(`LCFS_PWM_FALL_CYC),
	parameter lcfs_cnt_t STARTUP_CYC = lcfs_cnt_t'(`LCFS_STARTUP_CYC),
	parameter lcfs_cnt_t OVERTEMP_CYC = lcfs_cnt_t'(`LCFS_OVERTEMP_CYC),
	parameter lcfs_cnt_t OPEN_CYC = lcfs_cnt_t'(`LCFS_OPEN_CYC),
	parameter lcfs_cnt_t GSHORT_CYC = lcfs_cnt_t'(`LCFS_GSHORT_CYC),
	parameter lcfs_cnt_t LSHORT_CYC = lcfs_cnt_t'(`LCFS_LSHORT_CYC),
	parameter lcfs_cnt_t RECOVER_CYC = lcfs_cnt_t'(`LCFS_RECOVER_CYC)
)(
	// clock and power-on reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control pins
	input wire logic enable_in,
	input wire logic pwm_in,
	input wire logic diag_gate_input,
	// analog comparator levels
	input wire lcfs_sense_s sense,
	// shared fault bus, open drain
	input wire logic fault_bus_in,
	output logic fault_bus_out,
	output logic fault_bus_oe_n,
	// output stage commands and status
	output lcfs_drive_s drive,
	output lcfs_fault_s faults,
	output logic sleep_mode,
	output logic low_iq_mode
);
	lcfs_mode_e mode;
	lcfs_mode_e next_mode;
	lcfs_cnt_t mode_cnt;
	lcfs_cnt_t next_mode_cnt;
	logic pwm_eff;
	logic next_pwm_eff;
	lcfs_cnt_t pwm_cnt;
	lcfs_cnt_t next_pwm_cnt;
	logic pwm_d;
	logic diag_on;
	logic next_diag_on;
	logic chan_on;
	logic diag_active;
	logic flt_open;
	logic flt_gshort;
	logic flt_lshort;
	logic flt_ot;
	logic any_fault;
	logic bus_low;
	lcfs_drive_s next_drive;
	logic next_bus_oe_n;
	logic next_bus_out;
	logic awake;
	logic ext_low;
	logic pwm_edge;
	lcfs_cnt_t pwm_delay;
	logic diag_arm;
	lcfs_fault_s next_faults;
	logic next_sleep_mode;
	logic next_low_iq;

	// enable sequencing: sleep, start-up delay, run
	always_comb begin
		next_mode = mode;
		next_mode_cnt = '0;
		case (mode)
			LCFS_SLEEP: begin
				if (enable_in) begin
					next_mode = LCFS_START;
				end
			end
			LCFS_START: begin
				if (!enable_in) begin
					next_mode = LCFS_SLEEP; // RL11
				end else if (mode_cnt + 16'h0002 >= STARTUP_CYC) begin
					next_mode = LCFS_RUN; // RL3
				end else begin
					next_mode_cnt = mode_cnt + 16'h0001;
				end
			end
			LCFS_RUN: begin
				if (!enable_in) begin
					next_mode = LCFS_SLEEP; // RL11
				end
			end
			default: begin
				next_mode = LCFS_SLEEP;
			end
		endcase
	end

	// register sequencing state
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin // RL8
			mode <= LCFS_SLEEP;
			mode_cnt <= '0;
		end else begin
			mode <= next_mode;
			mode_cnt <= next_mode_cnt;
		end
	end

	// pwm edge and delay selection
	assign pwm_edge = (pwm_in != pwm_d);
	assign pwm_delay = pwm_in ? PWM_RISE_CYC : PWM_FALL_CYC; // RL1

	// delayed pwm: rises 17 us, falls 21 us after the pin changes
	always_comb begin
		next_pwm_eff = pwm_eff;
		next_pwm_cnt = '0;
		if (pwm_in != pwm_eff) begin
			if (pwm_edge) begin
				next_pwm_cnt = '0; // edge restarts delay
			end else if (pwm_cnt + 16'h0002 >= pwm_delay) begin
				next_pwm_eff = pwm_in; // RL1
			end else begin
				next_pwm_cnt = pwm_cnt + 16'h0001;
			end
		end
	end

	// register pwm delay state
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwm_eff <= 1'b0;
			pwm_cnt <= '0;
			pwm_d <= 1'b0;
		end else begin
			pwm_eff <= next_pwm_eff;
			pwm_cnt <= next_pwm_cnt;
			pwm_d <= pwm_in;
		end
	end

	// diag gate: comparator with hysteresis delivers a level; hold it
	always_comb begin
		next_diag_on = diag_gate_input; // RL13
	end

	// register diag gate level
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			diag_on <= 1'b0;
		end else begin
			diag_on <= next_diag_on;
		end
	end

	// channel state qualifiers
	assign chan_on = (mode == LCFS_RUN);
	assign diag_active = chan_on && pwm_in; // RL12
	assign bus_low = !fault_bus_in; // RL23
	assign awake = (mode != LCFS_SLEEP);
	assign ext_low = bus_low && !any_fault; // RL9
	assign diag_arm = diag_active && diag_on; // RL13

	// open circuit, also short to battery: headroom below assert level
	lcfs_deglitch u_open (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.arm(diag_arm), // RL15 RL13
		.set_cond(sense.open_assert_level), // RL14
		.restart(sense.open_release_level), // RL16
		.clr_cond(!sense.open_assert_level), // RL18
		.set_count(OPEN_CYC), // RL4
		.clr_count(RECOVER_CYC), // RL7
		.flag(flt_open)
	);

	// ground short: output below assert level while channel is on
	lcfs_deglitch u_gshort (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.arm(chan_on), // RL19
		.set_cond(sense.ground_short_assert_level),
		.restart(sense.ground_short_release_level), // RL20
		.clr_cond(sense.ground_short_release_level), // RL22
		.set_count(GSHORT_CYC), // RL5
		.clr_count(RECOVER_CYC), // RL7
		.flag(flt_gshort)
	);

	// single led short, gated by the diag gate
	lcfs_deglitch u_lshort (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.arm(diag_arm), // RL13
		.set_cond(sense.string_short),
		.restart(1'b0),
		.clr_cond(!sense.string_short), // RL24
		.set_count(LSHORT_CYC), // RL6
		.clr_count(RECOVER_CYC), // RL7
		.flag(flt_lshort)
	);

	// overtemperature, watched whenever the part is awake
	lcfs_deglitch u_ot (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.arm(awake),
		.set_cond(sense.overtemp),
		.restart(1'b0),
		.clr_cond(!sense.overtemp), // RL25
		.set_count(OVERTEMP_CYC), // RL2 RL26
		.clr_count(RECOVER_CYC),
		.flag(flt_ot)
	);

	assign any_fault = flt_open || flt_gshort || flt_lshort || flt_ot;

	// output drive decision, priority: not running (sleep or start-up), overtemp, shorts, open, bus
	always_comb begin
		next_drive = '0;
		next_bus_oe_n = !any_fault; // RL10 RL18
		next_bus_out = 1'b0; // open drain, only ever sinks
		if (!chan_on) begin
			next_drive = '0; // RL11
		end else if (flt_ot) begin
			next_drive = '0; // RL25
		end else if (flt_gshort || flt_lshort) begin
			next_drive.retry_on = 1'b1; // RL21 RL24
		end else if (ext_low) begin
			next_drive = '0; // RL9
		end else if (flt_open) begin
			next_drive.main_on = pwm_eff; // RL17
			next_drive.retry_on = !pwm_eff;
		end else if (bus_low) begin
			next_drive = '0; // RL23
		end else begin
			next_drive.main_on = pwm_eff; // RL12 RL1
		end
	end

	// register drive commands and bus pin
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			drive <= '0;
			fault_bus_oe_n <= 1'b1;
			fault_bus_out <= 1'b0;
		end else begin
			drive <= next_drive;
			fault_bus_oe_n <= next_bus_oe_n;
			fault_bus_out <= next_bus_out;
		end
	end

	// status flags for the outside
	always_comb begin
		next_faults.open = flt_open;
		next_faults.gshort = flt_gshort;
		next_faults.lshort = flt_lshort;
		next_faults.overtemp = flt_ot;
		next_sleep_mode = !awake; // RL11
		next_low_iq = ext_low; // RL9
	end

	// register status flags
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			faults <= '0;
			sleep_mode <= 1'b1;
			low_iq_mode <= 1'b0;
		end else begin
			faults <= next_faults;
			sleep_mode <= next_sleep_mode;
			low_iq_mode <= next_low_iq;
		end
	end
endmodule

//--- sim/lcfs_checker.sv
/* port assertions for the supervisor.
 assumes a bind from the bench top file. */
`timescale 1ns/1ps
module lcfs_checker
	import lcfs_pkg::*;
#(
	parameter lcfs_cnt_t OPEN_CYC = 16'h4,
	parameter lcfs_cnt_t GSHORT_CYC = 16'h4,
	parameter lcfs_cnt_t OVERTEMP_CYC = 16'h4
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// inputs
	input wire logic enable_in,
	input wire logic pwm_in,
	input wire logic diag_gate_input,
	input wire lcfs_sense_s sense,
	input wire logic fault_bus_in,
	// outputs
	input wire logic fault_bus_out,
	input wire logic fault_bus_oe_n,
	input wire lcfs_drive_s drive,
	input wire lcfs_fault_s faults,
	input wire logic sleep_mode,
	input wire logic low_iq_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	lcfs_cnt_t run_o;
	lcfs_cnt_t run_g;
	lcfs_cnt_t run_t;
	// length of the current run of the open, ground short and overtemp raw conditions
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_o <= '0;
			run_g <= '0;
			run_t <= '0;
		end else begin
			run_o <= sense.open_assert_level ? run_o + 16'h1 : '0;
			run_g <= sense.ground_short_assert_level ? run_g + 16'h1 : '0;
			run_t <= sense.overtemp ? run_t + 16'h1 : '0;
		end
	end
	sequence s_quiet;
		(faults == 4'h0)[*3];
	endsequence
	sequence s_ext_low;
		(!fault_bus_in && faults == 4'h0)[*3];
	endsequence
	// first reset edge may race the async reset at time zero, so skip it
	a_reset_vals: assert property (disable iff (1'b0) sys_rst && $past(sys_rst) |-> drive == 2'b00
		&& faults == 4'h0 && fault_bus_oe_n && sleep_mode && !low_iq_mode) else $error("outputs not at reset values");
	// run length up to the edge that set the internal flag
	a_open_min: assert property ($rose(faults.open) |-> $past(run_o) >= OPEN_CYC) else $error("open set early");
	a_gshort_min: assert property ($rose(faults.gshort) |-> $past(run_g) >= GSHORT_CYC) else $error("gshort early");
	a_temp_min: assert property ($rose(faults.overtemp) |-> $past(run_t) >= OVERTEMP_CYC) else $error("hot early");
	a_fault_sinks: assert property (faults != 4'h0 |-> ##[0:2] !fault_bus_oe_n) else $error("bus not sunk");
	a_bus_release: assert property (s_quiet |-> fault_bus_oe_n && !fault_bus_out) else $error("bus held");
	a_ext_off: assert property (s_ext_low |-> !drive.main_on && low_iq_mode) else $error("no low iq");
	a_gshort_drive: assert property ((faults.gshort && !faults.overtemp)[*2] |-> drive == 2'b01)
		else $error("gshort drive wrong");
	a_fault_off: assert property ((faults.lshort || faults.overtemp)[*2] |-> !drive.main_on)
		else $error("output on in fault");
	a_start_wait: assert property ($rose(enable_in) |-> (!drive.main_on)[*8]) else $error("started early");
	a_sleep_off: assert property ((!enable_in)[*3] |-> drive == 2'b00 && sleep_mode) else $error("awake");
	a_diag_gate: assert property ((!diag_gate_input)[*3] |-> !$rose(faults.open) && !$rose(faults.lshort))
		else $error("gated check fired");
endmodule

//--- sim/lcfs_sibling.sv
/* sibling driver sharing the open-drain fault bus.
 assumes the bench commands when the sibling sinks. */
`timescale 1ns/1ps
module lcfs_sibling (
	// clock and command
	input wire logic core_clk,
	input wire logic sink_cmd,
	// supervisor pin
	input wire logic dut_out,
	input wire logic dut_oe_n,
	// resolved bus
	output logic bus_level,
	output logic sib_off
);
	logic sib_sink;
	// sibling sinks one cycle after its own fault
	always_ff @(posedge core_clk) begin
		sib_sink <= sink_cmd;
	end
	// wired low with internal pull-up
	assign bus_level = !(sib_sink || (!dut_oe_n && !dut_out));
	// sibling shuts down while the bus is low
	assign sib_off = !bus_level;
endmodule

//--- sim/lcfs_supervisor_tb.sv
/* self-checking bench for the supervisor.
 assumes short deglitch counts set below. */
`timescale 1ns/1ps
module lcfs_supervisor_tb;
	import lcfs_pkg::*;
	localparam lcfs_cnt_t RISE = 16'h4, FALL = 16'h5, START = 16'ha, TEMP = 16'h8;
	localparam lcfs_cnt_t OPEN = 16'hc, GS = 16'hc, LS = 16'hc, REC = 16'h6;
	logic core_clk = 1'b0;
	logic sys_rst, enable_in, pwm_in, diag_gate_input, fault_bus_in, sink_cmd;
	logic fault_bus_out, fault_bus_oe_n, sleep_mode, low_iq_mode, sib_off;
	lcfs_sense_s sense;
	lcfs_drive_s drive;
	lcfs_fault_s faults;
	int n_errors = 0;
	int tests_run = 0;
	int n;
	// 50 mhz clock
	always #10 core_clk = ~core_clk;
	lcfs_supervisor #(.PWM_RISE_CYC(RISE), .PWM_FALL_CYC(FALL), .STARTUP_CYC(START), .OVERTEMP_CYC(TEMP),
		.OPEN_CYC(OPEN), .GSHORT_CYC(GS), .LSHORT_CYC(LS), .RECOVER_CYC(REC)) u_lcfs_supervisor (
		.core_clk(core_clk), .sys_rst(sys_rst), .enable_in(enable_in), .pwm_in(pwm_in),
		.diag_gate_input(diag_gate_input), .sense(sense), .fault_bus_in(fault_bus_in),
		.fault_bus_out(fault_bus_out), .fault_bus_oe_n(fault_bus_oe_n), .drive(drive), .faults(faults),
		.sleep_mode(sleep_mode), .low_iq_mode(low_iq_mode));
	lcfs_sibling u_lcfs_sibling (.core_clk(core_clk), .sink_cmd(sink_cmd), .dut_out(fault_bus_out),
		.dut_oe_n(fault_bus_oe_n), .bus_level(fault_bus_in), .sib_off(sib_off));
	// compare and count
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task tk(input int c);
		repeat (c) @(negedge core_clk);
	endtask
	function logic probe(input int k);
		case (k)
			0: probe = drive.main_on;
			1: probe = faults.open;
			2: probe = faults.gshort;
			3: probe = faults.lshort;
			4: probe = faults.overtemp;
			default: probe = low_iq_mode;
		endcase
	endfunction
	// cycles until a probe reaches a level
	task wt(input int k, input logic v);
		n = 0;
		while (probe(k) !== v && n < 300) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	task in_rng(input int lo);
		chk(16'(n >= lo && n <= lo + 4), 16'h1);
	endtask
	task t_reset;
		chk({drive, faults, fault_bus_oe_n, sleep_mode, low_iq_mode}, 16'h6);
		$display("reset test done");
	endtask
	task t_start_pwm;
		enable_in = 1'b1;
		pwm_in = 1'b1;
		diag_gate_input = 1'b1;
		wt(0, 1'b1);
		in_rng(START);
		chk(sleep_mode, 16'h0);
		pwm_in = 1'b0;
		wt(0, 1'b0);
		in_rng(FALL);
		pwm_in = 1'b1;
		wt(0, 1'b1);
		in_rng(RISE);
		$display("start and pwm test done");
	endtask
	task t_open;
		sense = 6'h24;
		tk(OPEN - 3);
		sense = 6'h14;
		tk(1);
		sense = 6'h24;
		wt(1, 1'b1);
		in_rng(OPEN);
		chk({fault_bus_oe_n, faults.gshort, faults.lshort, drive.main_on}, 16'h1);
		pwm_in = 1'b0;
		tk(FALL + 3);
		chk(drive, 16'h1);
		pwm_in = 1'b1;
		tk(RISE + 3);
		sense = 6'h14;
		wt(1, 1'b0);
		in_rng(REC);
		tk(2);
		chk(fault_bus_oe_n, 16'h1);
		$display("open test done");
	endtask
	task t_gated;
		pwm_in = 1'b0;
		sense = 6'h26;
		tk(3 * OPEN);
		chk({faults.open, faults.lshort}, 16'h0);
		pwm_in = 1'b1;
		diag_gate_input = 1'b0;
		tk(3 * OPEN);
		chk({faults.open, faults.lshort}, 16'h0);
		sense = 6'h14;
		diag_gate_input = 1'b1;
		tk(RISE + 3);
		$display("gated test done");
	endtask
	task t_gshort;
		sense = 6'h18;
		tk(GS - 3);
		sense = 6'h14;
		tk(1);
		sense = 6'h18;
		wt(2, 1'b1);
		in_rng(GS);
		chk(fault_bus_oe_n, 16'h0);
		pwm_in = 1'b0;
		tk(FALL + 3);
		chk(drive, 16'h1);
		pwm_in = 1'b1;
		tk(RISE + 3);
		chk(drive, 16'h1);
		sense = 6'h14;
		wt(2, 1'b0);
		in_rng(REC);
		wt(0, 1'b1);
		chk(16'(n <= RISE + 4), 16'h1);
		$display("ground short test done");
	endtask
	task t_lshort_hot;
		sense = 6'h16;
		wt(3, 1'b1);
		in_rng(LS);
		tk(2);
		chk(drive, 16'h1);
		sense = 6'h14;
		wt(3, 1'b0);
		in_rng(REC);
		tk(RISE + 4);
		sense = 6'h15;
		wt(4, 1'b1);
		in_rng(TEMP);
		tk(2);
		chk({drive.main_on, fault_bus_oe_n}, 16'h0);
		sense = 6'h14;
		wt(4, 1'b0);
		in_rng(REC);
		tk(RISE + 4);
		$display("led short and thermal test done");
	endtask
	task t_bus_sleep;
		sink_cmd = 1'b1;
		wt(5, 1'b1);
		chk(16'(n <= 4), 16'h1);
		chk({drive, sib_off}, 16'h1);
		sink_cmd = 1'b0;
		wt(5, 1'b0);
		chk(16'(n <= 4), 16'h1);
		wt(0, 1'b1);
		chk(drive.main_on, 16'h1);
		enable_in = 1'b0;
		tk(3);
		chk({drive, sleep_mode}, 16'h1);
		sys_rst = 1'b1;
		tk(2);
		t_reset;
		sys_rst = 1'b0;
		$display("bus and sleep test done");
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// main sequence, inputs change at falling edges
	initial begin
		sys_rst = 1'b1;
		enable_in = 1'b0;
		pwm_in = 1'b0;
		diag_gate_input = 1'b0;
		sink_cmd = 1'b0;
		sense = 6'h14;
		tk(6);
		t_reset;
		sys_rst = 1'b0;
		t_start_pwm;
		t_open;
		t_gated;
		t_gshort;
		t_lshort_hot;
		t_bus_sleep;
		tally_and_finish;
	end
	// hang guard, well past the expected run
	initial begin
		#200000;
		n_errors++;
		tally_and_finish;
	end
endmodule
bind lcfs_supervisor lcfs_checker #(.OPEN_CYC(OPEN_CYC), .GSHORT_CYC(GSHORT_CYC), .OVERTEMP_CYC(OVERTEMP_CYC))
	u_lcfs_checker (.core_clk(core_clk), .sys_rst(sys_rst), .enable_in(enable_in), .pwm_in(pwm_in),
	.diag_gate_input(diag_gate_input), .sense(sense), .fault_bus_in(fault_bus_in), .fault_bus_out(fault_bus_out),
	.fault_bus_oe_n(fault_bus_oe_n), .drive(drive), .faults(faults), .sleep_mode(sleep_mode),
	.low_iq_mode(low_iq_mode));
